// *** hw/jisps_top.sv ***
// TAP, instruction capture status and revision protection of a config flash.
// Assumes I_TCK is a host clock that may stop between scans and the flash array sits on I_CLOCK.
// Functional notes
// RULE_01: During ISC drive chain-enable high, others released.
// RULE_02: Read-protected revision refuses readback and verify.
// RULE_03: Read protect per revision, cleared by erase.
// RULE_04: Write protect blocks; unlock then erase clears.
// RULE_05: Host pauses by stopping TCK in shift.
// RULE_06: Capture pattern loaded, shifted out LSB first.
// RULE_07: Sixteen-bit instruction register between TDI, TDO.
// RULE_08: Capture bits 15:9 read zero.
// RULE_09: Bits 8:7 give ISC result code.
// RULE_10: Bits 6:5 give erase/program result code.
// RULE_11: Bit 4 zero while erase/program busy.
// RULE_12: Bit 3 set while in ISC mode.
// RULE_13: Bit 2 set when sampled revision done.
// RULE_14: Bits 1:0 always read 01.
// RULE_15: Bypass, sample/preload, extest opcodes decoded.
// RULE_16: Clamp holds boundary values, bypass selected.
// RULE_17: High-Z opcode releases all outputs together.
// RULE_18: Opcode 00FE shifts 32-bit identification.
// RULE_19: Opcode 00FD shifts 32-bit user code.
// RULE_20: Config opcode pulses start low, reselects revision.
// RULE_21: Blank user code reads all ones.
// RULE_22: Unknown opcodes select one-bit bypass.
`timescale 1ns/1ps
module jisps_top (
  // System clock and reset
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_SYS_RST,
  // JTAG link
  input  wire logic                          I_TCK,
  input  wire logic                          I_TMS,
  input  wire logic                          I_TDI,
  output logic                               O_TDO,
  output logic                               O_TDO_OE,
  // Revision select
  input  wire logic [jisps_pkg::REV_W-1:0]   I_REVISION_SELECT_PINS,
  input  wire logic [jisps_pkg::REV_W-1:0]   I_REV_SEL_INTERNAL,
  input  wire logic                          I_REV_SEL_FROM_PINS,
  output logic      [jisps_pkg::REV_W-1:0]   O_ACTIVE_REV,
  // Device pins
  input  wire logic                          I_CHAIN_ENABLE_FUNC,
  output logic                               O_CHAIN_ENABLE_OUT,
  output logic                               O_CHAIN_ENABLE_OUT_OE,
  output logic                               O_CONFIG_START_N,
  output logic                               O_CONFIG_START_N_OE,
  // Flash array
  output logic                               O_ARRAY_ERASE,
  output logic                               O_ARRAY_PROGRAM,
  output logic                               O_ARRAY_READ,
  output logic      [jisps_pkg::REV_W-1:0]   O_ARRAY_REV,
  input  wire logic                          I_ARRAY_BUSY,
  input  wire logic                          I_ARRAY_FAIL,
  output logic                               O_ISC_MODE
);
  import jisps_pkg::*;

  // ***************************************************************
  // TAP controller (link domain)
  // ***************************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jisps_tap_e;

  logic       trst_s1_q, trst_s2_q;          // System reset into link domain
  jisps_tap_e tap_q, tap_d;                  // TAP state

  // Reset synchroniser for the link domain
  always_ff @(posedge I_TCK) begin
    trst_s1_q <= I_SYS_RST;
    trst_s2_q <= trst_s1_q;
  end

  // Next state from TMS
  always_comb begin
    unique case (tap_q)
      TLR:     tap_d = I_TMS ? TLR    : RTI;
      RTI:     tap_d = I_TMS ? SEL_DR : RTI;
      SEL_DR:  tap_d = I_TMS ? SEL_IR : CAP_DR;
      CAP_DR:  tap_d = I_TMS ? EX1_DR : SH_DR;
      SH_DR:   tap_d = I_TMS ? EX1_DR : SH_DR;
      EX1_DR:  tap_d = I_TMS ? UPD_DR : PA_DR;
      PA_DR:   tap_d = I_TMS ? EX2_DR : PA_DR;
      EX2_DR:  tap_d = I_TMS ? UPD_DR : SH_DR;
      UPD_DR:  tap_d = I_TMS ? SEL_DR : RTI;
      SEL_IR:  tap_d = I_TMS ? TLR    : CAP_IR;
      CAP_IR:  tap_d = I_TMS ? EX1_IR : SH_IR;
      SH_IR:   tap_d = I_TMS ? EX1_IR : SH_IR;
      EX1_IR:  tap_d = I_TMS ? UPD_IR : PA_IR;
      PA_IR:   tap_d = I_TMS ? EX2_IR : PA_IR;
      EX2_IR:  tap_d = I_TMS ? UPD_IR : SH_IR;
      UPD_IR:  tap_d = I_TMS ? SEL_DR : RTI;
    endcase
  end

  // RULE_05: pause by held clock
  // A stopped TCK simply freezes the state in a shift state.
  always_ff @(posedge I_TCK) begin
    if (trst_s2_q) tap_q <= TLR;
    else           tap_q <= tap_d;
  end

  // ***************************************************************
  // Status crossing into the link domain
  // ***************************************************************
  logic [ST_W-1:0] st_sys;                   // Status levels, system side
  logic [ST_W-1:0] st_s1_q, st_s2_q;         // Two-flop synchronisers
  logic [REV_W-1:0] pin_s1_q, pin_s2_q;      // Revision pins for boundary
  genvar g;
  for (g = 0; g < ST_W; g++) begin : g_st_sync
    // Each status bit is a slow level
    always_ff @(posedge I_TCK) begin
      st_s1_q[g] <= st_sys[g];
      st_s2_q[g] <= st_s1_q[g];
    end
  end

  // Revision pins sampled for the boundary register
  always_ff @(posedge I_TCK) begin
    pin_s1_q <= I_REVISION_SELECT_PINS;
    pin_s2_q <= pin_s1_q;
  end

  // ***************************************************************
  // Instruction register and decode
  // ***************************************************************
  logic [IR_W-1:0] ir_sh_q;                  // Instruction shift stage
  logic [IR_W-1:0] ir_q;                     // Current instruction
  logic [IR_W-1:0] ir_cap;                   // Capture pattern
  logic [IR_W-1:0] cmd_q;                    // Command handed to system side
  logic            cmd_tgl_q;                // Toggles per command
  logic            isc_lk;                   // ISC mode seen in link domain
  // RULE_08: reserved bits zero
  // RULE_09: ISC result field
  // RULE_10: erase/program result field
  // RULE_11: busy reads zero
  // RULE_12: ISC mode bit
  // RULE_13: revision done bit
  // RULE_14: fixed low bits
  assign ir_cap = {IR_RSVD, st_s2_q[6:5], st_s2_q[4:3], ~st_s2_q[2], st_s2_q[1],
                   st_s2_q[0], IR_FIXED};
  assign isc_lk = st_s2_q[1];

  wire dec_bsr    = (ir_q == OP_SAMPLE) || (ir_q == OP_EXTEST);   // Boundary DR
  wire dec_id     = (ir_q == OP_IDCODE);
  wire dec_user   = (ir_q == OP_USERCODE) || (ir_q == OP_USR_PROG);
  wire dec_addr   = (ir_q == OP_ISC_ADDR);
  wire drive_bsr  = (ir_q == OP_EXTEST) || (ir_q == OP_CLAMP);    // Pins from cells
  wire drive_hiz  = (ir_q == OP_HIGHZ);
  wire is_cmd     = (ir_sh_q == OP_CONFIG)   || (ir_sh_q == OP_ISC_EN)   ||
                    (ir_sh_q == OP_ISC_DIS)  || (ir_sh_q == OP_ISC_PROG) ||
                    (ir_sh_q == OP_ISC_ERAS) || (ir_sh_q == OP_ISC_READ) ||
                    (ir_sh_q == OP_UNLOCK)   || (ir_sh_q == OP_SET_RP)   ||
                    (ir_sh_q == OP_SET_WP);

  // RULE_06: capture then shift LSB first
  // RULE_07: sixteen-bit path in IR scans
  always_ff @(posedge I_TCK) begin
    if (tap_q == CAP_IR)     ir_sh_q <= ir_cap;
    else if (tap_q == SH_IR) ir_sh_q <= {I_TDI, ir_sh_q[IR_W-1:1]};
  end

  // Instruction update; reset selects the identification register
  always_ff @(posedge I_TCK) begin
    if (trst_s2_q || tap_q == TLR) ir_q <= IR_RESET;
    else if (tap_q == UPD_IR)      ir_q <= ir_sh_q;
  end

  // RULE_20: config request handed over
  // Commands launch at instruction update as a toggle plus a held code.
  always_ff @(posedge I_TCK) begin
    if (trst_s2_q) begin
      cmd_q     <= OP_BYPASS;
      cmd_tgl_q <= 1'b0;
    end else if (tap_q == UPD_IR && is_cmd) begin
      cmd_q     <= ir_sh_q;
      cmd_tgl_q <= ~cmd_tgl_q;
    end
  end

  // ***************************************************************
  // Data registers
  // ***************************************************************
  logic [DR_W-1:0]  dr_q;                    // Shared data shift stage
  logic [DR_W-1:0]  dr_top;                  // One-hot entry point for TDI
  logic [DR_W-1:0]  dr_cap;                  // Capture value
  logic [31:0]      user_q;                  // User code register
  logic [REV_W-1:0] rev_q;                   // Addressed revision
  logic [BSR_W-1:0] bsu_q;                   // Boundary update stage
  logic [BSR_W-1:0] bs_pins;                 // Sampled pin states
  int unsigned      dr_len;                  // Selected length

  // RULE_15: standard boundary selection
  // RULE_16: clamp keeps bypass path
  // RULE_22: default to bypass
  assign dr_len = dec_bsr  ? DR_LEN_BSR  :
                  dec_id   ? DR_LEN_32   :
                  dec_user ? DR_LEN_32   :
                  dec_addr ? DR_LEN_ADDR : DR_LEN_BYP;
  assign dr_top = DR_W'(1) << (dr_len - 1);

  // Cell 0 nearest TDO: start oe, start value, chain oe, chain value, pins
  assign bs_pins = {pin_s2_q[0], pin_s2_q[1], O_CHAIN_ENABLE_OUT,
                    O_CHAIN_ENABLE_OUT_OE, O_CONFIG_START_N, O_CONFIG_START_N_OE};

  // RULE_18: identification value
  // RULE_19: user code value
  assign dr_cap = dec_bsr  ? {{(DR_W-BSR_W){1'b0}}, bs_pins} :
                  dec_id   ? ID_VALUE :
                  dec_user ? user_q   :
                  dec_addr ? {{(DR_W-REV_W){1'b0}}, rev_q} : '0;

  // Shift stage: TDI enters at the top of the selected length
  always_ff @(posedge I_TCK) begin
    if (tap_q == CAP_DR)     dr_q <= dr_cap;
    else if (tap_q == SH_DR) dr_q <= ({1'b0, dr_q[DR_W-1:1]} & ~dr_top) |
                                     (I_TDI ? dr_top : '0);
  end

  // RULE_21: blank user code all ones
  always_ff @(posedge I_TCK) begin
    if (trst_s2_q) begin
      user_q <= USER_BLANK;
      rev_q  <= '0;
      bsu_q  <= '0;
    end else if (tap_q == UPD_DR) begin
      if (ir_q == OP_USR_PROG && isc_lk) user_q <= dr_q;
      if (dec_addr)                      rev_q  <= dr_q[REV_W-1:0];
      if (dec_bsr)                       bsu_q  <= dr_q[BSR_W-1:0];
    end
  end

  // TDO changes on the falling edge, driven only in shift states
  always_ff @(negedge I_TCK) begin
    if (trst_s2_q) begin
      O_TDO    <= 1'b0;
      O_TDO_OE <= 1'b0;
    end else begin
      O_TDO    <= (tap_q == SH_IR) ? ir_sh_q[0] : dr_q[0];
      O_TDO_OE <= (tap_q == SH_IR) || (tap_q == SH_DR);
    end
  end

  // ***************************************************************
  // System domain: command receive
  // ***************************************************************
  logic              tg_s1_q, tg_s2_q, tg_s3_q; // Command toggle synchroniser
  logic              cmd_go;                    // One pulse per command
  logic [REV_W-1:0]  op_rev;                    // Revision of the command
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else begin
      tg_s1_q <= cmd_tgl_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end
  assign cmd_go = tg_s2_q ^ tg_s3_q;
  assign op_rev = rev_q;                        // Held stable between commands

  // ***************************************************************
  // System domain: protection and operations
  // ***************************************************************
  typedef enum logic [1:0] {OP_IDLE, OP_LAUNCH, OP_WAIT} jisps_op_e;
  jisps_op_e        op_q;                    // Array operation state
  logic             op_is_prog_q;            // Running operation is program
  logic [NREV-1:0]  rp_q, wp_q, done_q;      // Per-revision flags
  logic             isc_q, unlock_q;         // ISC mode, unlock armed
  logic [1:0]       isc_err_q, ep_err_q;     // Result fields
  logic [REV_W-1:0] act_rev_q;               // Active revision
  logic             cf_q;                    // Start pulse, active high
  logic [REV_W-1:0] rsel_s1_q, rsel_s2_q;    // Revision pins synchroniser
  logic [REV_W-1:0] arr_rev_q;               // Revision given to the array

  wire c_en    = cmd_go && cmd_q == OP_ISC_EN;
  wire c_dis   = cmd_go && cmd_q == OP_ISC_DIS;
  wire c_prog  = cmd_go && cmd_q == OP_ISC_PROG && isc_q;
  wire c_eras  = cmd_go && cmd_q == OP_ISC_ERAS && isc_q;
  wire c_read  = cmd_go && cmd_q == OP_ISC_READ && isc_q;
  wire c_unl   = cmd_go && cmd_q == OP_UNLOCK   && isc_q;
  wire c_srp   = cmd_go && cmd_q == OP_SET_RP   && isc_q;
  wire c_swp   = cmd_go && cmd_q == OP_SET_WP   && isc_q;
  wire c_cfg   = cmd_go && cmd_q == OP_CONFIG;
  wire c_isc   = cmd_go && !isc_q && cmd_q != OP_ISC_EN && cmd_q != OP_CONFIG &&
                 cmd_q != OP_ISC_DIS;        // Programming command outside ISC
  wire idle    = (op_q == OP_IDLE);
  // RULE_04: unlock must come just before erase
  wire wp_hit  = wp_q[op_rev];
  wire erase_ok = c_eras && idle && (!wp_hit || unlock_q);
  wire prog_ok  = c_prog && idle && !wp_hit;
  // RULE_02: read refused when protected
  wire read_ok  = c_read && idle && !rp_q[op_rev];
  wire ep_refused = (c_eras && !erase_ok) || (c_prog && !prog_ok);

  // Revision pins pass two flops before use
  always_ff @(posedge I_CLOCK) begin
    rsel_s1_q <= I_REVISION_SELECT_PINS;
    rsel_s2_q <= rsel_s1_q;
  end

  // Operation sequencer: launch, then wait for the array to go idle
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      op_q         <= OP_IDLE;
      op_is_prog_q <= 1'b0;
      arr_rev_q    <= '0;
    end else begin
      unique case (op_q)
        OP_IDLE: if (erase_ok || prog_ok) begin
          op_q         <= OP_LAUNCH;
          op_is_prog_q <= prog_ok;
          arr_rev_q    <= op_rev;
        end
        OP_LAUNCH: op_q <= OP_WAIT;
        OP_WAIT:   if (!I_ARRAY_BUSY) op_q <= OP_IDLE;
      endcase
    end
  end
  assign O_ARRAY_ERASE   = (op_q == OP_LAUNCH) && !op_is_prog_q;
  assign O_ARRAY_PROGRAM = (op_q == OP_LAUNCH) && op_is_prog_q;
  assign O_ARRAY_READ    = read_ok;
  assign O_ARRAY_REV     = (op_q == OP_IDLE) ? op_rev : arr_rev_q;

  wire op_end = (op_q == OP_WAIT) && !I_ARRAY_BUSY;

  // Mode, unlock and result fields
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      isc_q     <= 1'b0;
      unlock_q  <= 1'b0;
      isc_err_q <= CODE_NONE;
      ep_err_q  <= CODE_NONE;
    end else begin
      if (c_en)       isc_q <= 1'b1;
      else if (c_dis) isc_q <= 1'b0;
      // Any command other than unlock consumes the armed unlock
      if (cmd_go) unlock_q <= c_unl;
      if (c_en)                        isc_err_q <= CODE_OK;
      else if (c_isc || (c_read && !read_ok)) isc_err_q <= CODE_FAIL;
      if (ep_refused)  ep_err_q <= CODE_FAIL;
      else if (op_end) ep_err_q <= I_ARRAY_FAIL ? CODE_FAIL : CODE_OK;
    end
  end

  // Per-revision protection and done flags
  for (g = 0; g < NREV; g++) begin : g_rev
    wire hit = (op_rev == REV_W'(g));
    wire own = (arr_rev_q == REV_W'(g));
    always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
        rp_q[g]   <= 1'b0;
        wp_q[g]   <= 1'b0;
        done_q[g] <= 1'b0;
      end else begin
        // RULE_03: erase alone clears read protect
        if (erase_ok && hit)    rp_q[g] <= 1'b0;
        else if (c_srp && hit)  rp_q[g] <= 1'b1;
        // RULE_04: erase after unlock clears lock
        if (erase_ok && hit)    wp_q[g] <= 1'b0;
        else if (c_swp && hit)  wp_q[g] <= 1'b1;
        if ((erase_ok || prog_ok) && hit)      done_q[g] <= 1'b0;
        else if (op_end && own && op_is_prog_q) done_q[g] <= !I_ARRAY_FAIL;
      end
    end
  end

  // RULE_20: one start pulse, revision reselect
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      cf_q      <= 1'b0;
      act_rev_q <= '0;
    end else begin
      cf_q <= c_cfg;
      if (c_cfg) act_rev_q <= I_REV_SEL_FROM_PINS ? rsel_s2_q : I_REV_SEL_INTERNAL;
    end
  end
  assign O_ACTIVE_REV = act_rev_q;
  assign O_ISC_MODE   = isc_q;

  // Status levels sent to the capture pattern
  assign st_sys = {isc_err_q, ep_err_q, (op_q != OP_IDLE), isc_q, done_q[act_rev_q]};

  // ***************************************************************
  // Pin drive
  // ***************************************************************
  // RULE_17: high-Z releases everything
  // RULE_01: ISC drives chain-enable high only
  // RULE_16: clamp drives boundary values
  // System-side mode level: pins must follow even while TCK is stopped
  wire isc_pin = isc_q;
  assign O_CHAIN_ENABLE_OUT    = drive_bsr ? bsu_q[3] : (isc_pin | I_CHAIN_ENABLE_FUNC);
  assign O_CHAIN_ENABLE_OUT_OE = drive_hiz ? 1'b0 : (drive_bsr ? bsu_q[2] : 1'b1);
  assign O_CONFIG_START_N      = drive_bsr ? bsu_q[1] : ~cf_q;
  assign O_CONFIG_START_N_OE   = drive_hiz ? 1'b0 :
                                 (drive_bsr ? bsu_q[0] : (!isc_pin && cf_q));
endmodule

// *** include/jisps_pkg.sv ***
// Constants shared by the JTAG / in-system programming security block.
// Assumes a 16-bit instruction register and four design revisions.
package jisps_pkg;
  // ***************************************************************
  // Instruction register layout
  // ***************************************************************
  localparam int          IR_W        = 16;             // Instruction length
  localparam int          REV_W       = 2;              // Revision index width
  localparam int          NREV        = 4;              // Number of revisions
  localparam int          DR_W        = 32;             // Longest data register
  localparam int          BSR_W       = 6;              // Boundary cells
  localparam logic [1:0]  CODE_OK     = 2'b10;          // Result: success
  localparam logic [1:0]  CODE_FAIL   = 2'b01;          // Result: failure
  localparam logic [1:0]  CODE_NONE   = 2'b00;          // Result: nothing yet
  localparam logic [1:0]  IR_FIXED    = 2'b01;          // Capture bits 1:0
  localparam logic [6:0]  IR_RSVD     = 7'h00;          // Capture bits 15:9
  // ***************************************************************
  // Opcodes, public
  // ***************************************************************
  localparam logic [15:0] OP_BYPASS   = 16'hFFFF;
  localparam logic [15:0] OP_SAMPLE   = 16'h0001;
  localparam logic [15:0] OP_EXTEST   = 16'h0000;
  localparam logic [15:0] OP_CLAMP    = 16'h00FA;
  localparam logic [15:0] OP_HIGHZ    = 16'h00FC;
  localparam logic [15:0] OP_IDCODE   = 16'h00FE;
  localparam logic [15:0] OP_USERCODE = 16'h00FD;
  localparam logic [15:0] OP_CONFIG   = 16'h00EE;
  // ***************************************************************
  // Opcodes, private programming set
  // ***************************************************************
  localparam logic [15:0] OP_ISC_EN   = 16'h00E8;       // Enter ISC mode
  localparam logic [15:0] OP_ISC_DIS  = 16'h00F0;       // Leave ISC mode
  localparam logic [15:0] OP_ISC_ADDR = 16'h00EB;       // Revision address DR
  localparam logic [15:0] OP_ISC_PROG = 16'h00EA;       // Program revision
  localparam logic [15:0] OP_ISC_ERAS = 16'h00EC;       // Erase revision
  localparam logic [15:0] OP_ISC_READ = 16'h00EF;       // Read / verify
  localparam logic [15:0] OP_UNLOCK   = 16'h00AA;       // Arm write unlock
  localparam logic [15:0] OP_SET_RP   = 16'h00B0;       // Set read protect
  localparam logic [15:0] OP_SET_WP   = 16'h00B1;       // Set write protect
  localparam logic [15:0] OP_USR_PROG = 16'h00B2;       // Load user code
  // ***************************************************************
  // Identity and reset values
  // ***************************************************************
  localparam logic [31:0] ID_VALUE    = 32'h0000_1001;  // Arbitrary value, LSB one
  localparam logic [31:0] USER_BLANK  = 32'hFFFF_FFFF;  // Blank user code
  localparam logic [15:0] IR_RESET    = OP_IDCODE;      // Instruction after reset
  localparam int          DR_LEN_BYP  = 1;
  localparam int          DR_LEN_ADDR = 16;
  localparam int          DR_LEN_32   = 32;
  localparam int          DR_LEN_BSR  = BSR_W;
  localparam int          ST_W        = 7;              // Status bits crossing
endpackage

// *** testbench/jisps_assertions.sv ***
// Checker: pin release, config pulse and array pulse rules.
// Sees only top ports; bound from the bench top file.
`timescale 1ns/1ps
module jisps_assertions (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_ARRAY_BUSY,
  input wire logic O_ISC_MODE,
  input wire logic O_CHAIN_ENABLE_OUT,
  input wire logic O_CHAIN_ENABLE_OUT_OE,
  input wire logic O_CONFIG_START_N,
  input wire logic O_CONFIG_START_N_OE,
  input wire logic O_ARRAY_ERASE,
  input wire logic O_ARRAY_PROGRAM,
  input wire logic O_ARRAY_READ
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  chain_high_a: assert property (O_ISC_MODE && O_CHAIN_ENABLE_OUT_OE |-> O_CHAIN_ENABLE_OUT)
    else $error("chain enable not high in isc");
  cfg_released_a: assert property (O_ISC_MODE |-> !O_CONFIG_START_N_OE)
    else $error("config start driven in isc");
  cfg_low_a: assert property (O_CONFIG_START_N_OE |-> !O_CONFIG_START_N)
    else $error("config start driven high");
  cfg_pulse_a: assert property ($rose(O_CONFIG_START_N_OE) |=> !O_CONFIG_START_N_OE)
    else $error("config start pulse too long");
  erase_once_a: assert property (O_ARRAY_ERASE |=> !O_ARRAY_ERASE)
    else $error("erase pulse too long");
  prog_once_a: assert property (O_ARRAY_PROGRAM |=> !O_ARRAY_PROGRAM)
    else $error("program pulse too long");
  op_in_isc_a: assert property (O_ARRAY_ERASE || O_ARRAY_PROGRAM |-> O_ISC_MODE)
    else $error("array op outside isc");
  read_in_isc_a: assert property (O_ARRAY_READ |-> O_ISC_MODE)
    else $error("read outside isc");
  busy_block_a: assert property (I_ARRAY_BUSY |-> !(O_ARRAY_ERASE || O_ARRAY_PROGRAM))
    else $error("array op while busy");
  cover property (O_ARRAY_ERASE);
  cover property (O_ARRAY_PROGRAM);
  cover property (O_ARRAY_READ);
  cover property ($rose(O_CONFIG_START_N_OE));
endmodule

// *** testbench/jisps_host.sv ***
// JTAG host model: TCK of 15 ns runs only inside scans and hold calls.
// Assumes the TAP rests in Run-Test/Idle between scans.
`timescale 1ns/1ps
module jisps_host (
  // TAP pins
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One TCK period; TDI shows the inverse once released
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #7.5 o_tck = 1'b1;
    tdo = i_tdo;
    #7.5 o_tck = 1'b0;
    o_tdi = ~tdi;
  endtask
  // Run n periods with TMS held at t
  task automatic hold(input logic t, input int n);
    logic b;
    repeat (n) step(t, 1'b0, b);
  endtask
  // no Pause states: Exit1 goes straight to Update
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    hold(1'b0, 2);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    hold(1'b0, 1);
  endtask
endmodule

// *** testbench/jisps_top_bench.sv ***
// Bench: status capture, opcode rows and revision protection.
// Drives the TAP through jisps_host and models the flash array.
`timescale 1ns/1ps
module jisps_top_bench;
  import jisps_pkg::*;
  localparam logic [31:0] PAT = 32'hA5A5_0F0F;
  localparam logic [31:0] BYP = {PAT[30:0], 1'b0};
  localparam logic [15:0] MSK = 16'hFE7F;
  logic        clk = 1'b0, rst = 1'b1, fpin = 1'b0;
  logic [1:0]  pins = 2'h0, rev, arev;
  logic        tck, tms, tdi, tdo, toe, ce, ceoe, cs, csoe, er, pg, rd, isc, busy;
  logic [15:0] cap;
  logic [31:0] d;
  int          err_total = 0, n_compared = 0, bcnt = 0, n_er = 0, n_rd = 0, n_cs = 0, n_pg = 0;
  logic [15:0] row_op [7] = '{OP_BYPASS, OP_CLAMP, OP_HIGHZ, 16'h1234, OP_IDCODE,
                              OP_USERCODE, OP_SAMPLE};
  logic [31:0] row_dr [7] = '{BYP, BYP, BYP, BYP, ID_VALUE, USER_BLANK, {PAT[25:0], 6'h06}};
  always #5 clk = ~clk;
  jisps_host jisps_host_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  jisps_top jisps_top_i (.I_CLOCK(clk), .I_SYS_RST(rst), .I_TCK(tck), .I_TMS(tms),
    .I_TDI(tdi), .O_TDO(tdo), .O_TDO_OE(toe), .I_REVISION_SELECT_PINS(pins),
    .I_REV_SEL_INTERNAL(2'h1), .I_REV_SEL_FROM_PINS(fpin), .O_ACTIVE_REV(rev),
    .I_CHAIN_ENABLE_FUNC(1'b0), .O_CHAIN_ENABLE_OUT(ce), .O_CHAIN_ENABLE_OUT_OE(ceoe),
    .O_CONFIG_START_N(cs), .O_CONFIG_START_N_OE(csoe), .O_ARRAY_ERASE(er),
    .O_ARRAY_PROGRAM(pg), .O_ARRAY_READ(rd), .O_ARRAY_REV(arev), .I_ARRAY_BUSY(busy),
    .I_ARRAY_FAIL(1'b0), .O_ISC_MODE(isc));
  // Flash array: busy 30 cycles per op; pulse counters
  assign busy = bcnt != 0;
  always @(posedge clk) begin
    if (er || pg) bcnt <= 30;
    else if (bcnt != 0) bcnt <= bcnt - 1;
    if (er) n_er <= n_er + 1;
    if (pg) n_pg <= n_pg + 1;
    if (rd) n_rd <= n_rd + 1;
    if (csoe && !cs) n_cs <= n_cs + 1;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Instruction scan, capture kept in cap
  task automatic ir(input logic [15:0] op);
    jisps_host_i.scan(1'b1, 16, {16'h0000, op}, d);
    cap = d[15:0];
    repeat (8) @(posedge clk);
  endtask
  // Command scan plus room for an array op
  task automatic cmd(input logic [15:0] op);
    ir(op);
    repeat (40) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d compares=%0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    jisps_host_i.hold(1'b1, 5);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    jisps_host_i.hold(1'b0, 4);
    ir(OP_BYPASS);
    cmp({toe, cap & MSK}, 17'h0_0011);
    for (int k = 0; k < 7; k++) begin
      ir(row_op[k]);
      if (row_op[k] === OP_HIGHZ) cmp({ceoe, csoe}, 2'b00);
      jisps_host_i.scan(1'b0, 32, PAT, d);
      cmp(d, row_dr[k]);
    end
    cmd(OP_ISC_EN);
    ir(OP_ISC_ADDR);
    jisps_host_i.scan(1'b0, 16, 32'h0000_0002, d);
    cmp({isc, ce, ceoe, csoe}, 4'b1110);
    cmd(OP_SET_WP);
    cmp(cap & MSK, 16'h0019);
    cmd(OP_ISC_ERAS);
    ir(OP_UNLOCK);
    cmp(cap & MSK, 16'h0039);
    cmp(n_er, 0);
    cmd(OP_ISC_ERAS);
    cmd(OP_ISC_PROG);
    cmp(cap & MSK, 16'h0059);
    cmp({n_er[1:0], arev}, 4'b0110);
    cmd(OP_SET_RP);
    cmd(OP_ISC_READ);
    ir(OP_BYPASS);
    cmp({cap[8:7], n_rd[1:0]}, 4'b0100);
    cmd(OP_ISC_ERAS);
    cmd(OP_ISC_READ);
    cmp(n_rd, 1);
    ir(OP_ISC_PROG);
    ir(OP_BYPASS);
    cmp(cap[4], 1'b0);
    repeat (40) @(posedge clk);
    cmd(OP_ISC_DIS);
    @(posedge clk);
    fpin <= 1'b1;
    pins <= 2'h2;
    repeat (4) @(posedge clk);
    cmd(OP_CONFIG);
    ir(OP_BYPASS);
    cmp(cap & 16'h000C, 16'h0004);
    cmp({rev, n_cs[1:0], n_pg[1:0]}, 6'b1001_10);
    report_and_stop();
  end
endmodule
bind jisps_top jisps_assertions jisps_assertions_i (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
  .I_ARRAY_BUSY(I_ARRAY_BUSY), .O_ISC_MODE(O_ISC_MODE), .O_CHAIN_ENABLE_OUT(O_CHAIN_ENABLE_OUT),
  .O_CHAIN_ENABLE_OUT_OE(O_CHAIN_ENABLE_OUT_OE), .O_CONFIG_START_N(O_CONFIG_START_N),
  .O_CONFIG_START_N_OE(O_CONFIG_START_N_OE), .O_ARRAY_ERASE(O_ARRAY_ERASE),
  .O_ARRAY_PROGRAM(O_ARRAY_PROGRAM), .O_ARRAY_READ(O_ARRAY_READ));
